// *** rtl/aug_prn_pkg.sv ***
package aug_prn_pkg;

    typedef enum logic [1:0] {
        state_idle = 2'b00,
        state_seek = 2'b01,
        state_run = 2'b10
    } gen_state_type;

    typedef enum logic [1:0] {
        select_prn = 2'b00,
        select_delay = 2'b01,
        select_state = 2'b10
    } code_select_type;

endpackage

// *** rtl/aug_prn_regs.svh ***
`ifndef AUG_PRN_REGS_SVH
`define AUG_PRN_REGS_SVH

// Code structure
`define CODE_LENGTH 10'h3FF
`define LAST_CHIP_INDEX 10'h3FE
`define REGISTER_ALL_ONES 10'h3FF
`define SYMBOL_CODE_PERIODS 1'h1

// Augmentation PRN range, 120 through 138
`define AUG_PRN_FIRST 8'h78
`define AUG_PRN_LAST 8'h8A

// Timing: chip rate and system clock
`define CHIP_RATE_HZ 64'h00000000000F9C18
`define CLOCK_RATE_HZ 64'h000000000BEBC200
`define PHASE_ACC_BITS 33

// Second register start states for PRN 120 .. 138
`define START_STATE_120 10'h246
`define START_STATE_121 10'h2A1
`define START_STATE_122 10'h0B7
`define START_STATE_123 10'h09A
`define START_STATE_124 10'h38F
`define START_STATE_125 10'h23E
`define START_STATE_126 10'h3F4
`define START_STATE_127 10'h1CF
`define START_STATE_128 10'h35A
`define START_STATE_129 10'h2A8
`define START_STATE_130 10'h0E1
`define START_STATE_131 10'h169
`define START_STATE_132 10'h150
`define START_STATE_133 10'h3D9
`define START_STATE_134 10'h1C6
`define START_STATE_135 10'h28E
`define START_STATE_136 10'h1E0
`define START_STATE_137 10'h207
`define START_STATE_138 10'h128

`endif

// *** rtl/augmentation_prn_code_generator.sv ***
`timescale 1ns/1ps
`include "aug_prn_regs.svh"

// Functional notes
// - 1023-chip Gold codes, C/A family.
// - Reserved GPS codes also producible.
// - Code chosen by PRN, delay or state.
// - Augmentation PRNs numbered 120 through 138.
// - No two-tap phase selection used.
// - Programmable second-register delay, single output.
// - Programmable second-register start state, single output.
// - Same hardware serves GPS and augmentation codes.
// - Ten-bit state: first chip is MSB.
// - First ten chips invert start state.
// - PRN 120 uses delay 145, state 1106.
// - Code rate coherent with carrier, ratio 1540.
// - 500 sps symbols XOR onto code chips.
// - Symbol boundary aligned, two code periods.
module augmentation_prn_code_generator #(
    parameter logic [31:0] CODE_STEP = 32'(((`CHIP_RATE_HZ << 32) + (`CLOCK_RATE_HZ >> 1))
                                           / `CLOCK_RATE_HZ)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Code selection from the host
    input wire logic start,
    input wire logic halt,
    input wire logic [1:0] code_select,
    input wire logic [7:0] prn_number,
    input wire logic [9:0] second_register_chip_delay,
    input wire logic [9:0] second_register_start_state,
    // Navigation symbols
    input wire logic data_symbol,
    // Chip stream to the modulator
    output logic code_chip,
    output logic tx_chip,
    output logic chip_strobe,
    output logic epoch,
    output logic symbol_take,
    // Status
    output logic running,
    output logic select_error
);

    ////////////////////////////////////////////////////////////////////////////
    // Start state lookup for the augmentation PRNs

    function automatic logic [9:0] prn_start_state(input logic [7:0] prn);
        logic [9:0] value;
        value = `REGISTER_ALL_ONES;
        unique case (prn)
            8'h78: value = `START_STATE_120;
            8'h79: value = `START_STATE_121;
            8'h7A: value = `START_STATE_122;
            8'h7B: value = `START_STATE_123;
            8'h7C: value = `START_STATE_124;
            8'h7D: value = `START_STATE_125;
            8'h7E: value = `START_STATE_126;
            8'h7F: value = `START_STATE_127;
            8'h80: value = `START_STATE_128;
            8'h81: value = `START_STATE_129;
            8'h82: value = `START_STATE_130;
            8'h83: value = `START_STATE_131;
            8'h84: value = `START_STATE_132;
            8'h85: value = `START_STATE_133;
            8'h86: value = `START_STATE_134;
            8'h87: value = `START_STATE_135;
            8'h88: value = `START_STATE_136;
            8'h89: value = `START_STATE_137;
            8'h8A: value = `START_STATE_138;
            default: value = `REGISTER_ALL_ONES;
        endcase
        return value;
    endfunction

    // Bit 9 is stage 10, the single output tap of each register
    function automatic logic [9:0] step_first(input logic [9:0] r);
        return {r[8:0], r[2] ^ r[9]};
    endfunction

    function automatic logic [9:0] step_second(input logic [9:0] r);
        return {r[8:0], r[1] ^ r[2] ^ r[5] ^ r[7] ^ r[8] ^ r[9]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    aug_prn_pkg::gen_state_type state, next_state;
    logic [9:0] first_feedback_register, next_first_feedback_register;
    logic [9:0] second_feedback_register, next_second_feedback_register;
    logic [9:0] second_base, next_second_base;
    logic [9:0] chip_index, next_chip_index;
    logic [9:0] seek_count, next_seek_count;
    logic [31:0] phase, next_phase;
    logic symbol_half, next_symbol_half;
    logic symbol, next_symbol;
    logic next_code_chip, next_tx_chip, next_chip_strobe, next_epoch;
    logic next_symbol_take, next_running, next_select_error;
    logic [`PHASE_ACC_BITS-1:0] phase_sum;
    logic chip_tick;
    logic chip_value;
    logic symbol_now;
    logic prn_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        next_state = state;
        next_first_feedback_register = first_feedback_register;
        next_second_feedback_register = second_feedback_register;
        next_second_base = second_base;
        next_chip_index = chip_index;
        next_seek_count = seek_count;
        next_phase = phase;
        next_symbol_half = symbol_half;
        next_symbol = symbol;
        next_code_chip = code_chip;
        next_tx_chip = tx_chip;
        next_chip_strobe = 1'b0;
        next_epoch = 1'b0;
        next_symbol_take = 1'b0;
        next_running = running;
        next_select_error = select_error;
        // Step derived from the shared clock, so a carrier NCO fed 1540 x step stays locked
        phase_sum = {1'b0, phase} + {1'b0, CODE_STEP};
        chip_tick = phase_sum[`PHASE_ACC_BITS-1];
        chip_value = first_feedback_register[9] ^ second_feedback_register[9];
        symbol_now = symbol;
        prn_ok = (prn_number >= `AUG_PRN_FIRST) && (prn_number <= `AUG_PRN_LAST);
        unique case (state)
            aug_prn_pkg::state_idle: begin
                if (start) begin
                    next_first_feedback_register = `REGISTER_ALL_ONES;
                    next_chip_index = 10'h000;
                    next_phase = 32'h00000000;
                    next_symbol_half = 1'b0;
                    next_select_error = 1'b0;
                    unique case (code_select)
                        aug_prn_pkg::select_prn: begin
                            // Start state replaces two-tap phase selection
                            next_second_feedback_register = prn_start_state(prn_number);
                            next_second_base = prn_start_state(prn_number);
                            next_state = prn_ok ? aug_prn_pkg::state_run : state;
                            next_running = prn_ok;
                            next_select_error = !prn_ok;
                        end
                        aug_prn_pkg::select_delay: begin
                            // Delay d equals starting 1023 - d chips further along
                            next_second_feedback_register = `REGISTER_ALL_ONES;
                            next_second_base = `REGISTER_ALL_ONES;
                            next_seek_count = `CODE_LENGTH - second_register_chip_delay;
                            if (second_register_chip_delay == `CODE_LENGTH) begin
                                next_select_error = 1'b1;
                            end else if (second_register_chip_delay == 10'h000) begin
                                next_state = aug_prn_pkg::state_run;
                                next_running = 1'b1;
                            end else begin
                                next_state = aug_prn_pkg::state_seek;
                            end
                        end
                        aug_prn_pkg::select_state: begin
                            // Any state serves the reserved GPS codes too
                            next_second_feedback_register = second_register_start_state;
                            next_second_base = second_register_start_state;
                            next_state = aug_prn_pkg::state_run;
                            next_running = 1'b1;
                        end
                        default: begin
                            next_select_error = 1'b1;
                        end
                    endcase
                end
            end
            aug_prn_pkg::state_seek: begin
                // Seeks at the system clock, at most 1022 cycles, no delay line memory
                next_second_feedback_register = step_second(second_feedback_register);
                next_seek_count = seek_count - 10'h001;
                if (seek_count == 10'h001) begin
                    next_second_base = step_second(second_feedback_register);
                    next_state = aug_prn_pkg::state_run;
                    next_running = 1'b1;
                end
                if (halt) begin
                    next_state = aug_prn_pkg::state_idle;
                    next_running = 1'b0;
                end
            end
            aug_prn_pkg::state_run: begin
                next_phase = phase_sum[31:0];
                if (chip_tick) begin
                    next_chip_strobe = 1'b1;
                    next_code_chip = chip_value;
                    if (chip_index == 10'h000) begin
                        next_epoch = 1'b1;
                        next_symbol_half = symbol_half ^ `SYMBOL_CODE_PERIODS;
                        if (!symbol_half) begin
                            symbol_now = data_symbol;
                            next_symbol = data_symbol;
                            next_symbol_take = 1'b1;
                        end
                    end
                    next_tx_chip = chip_value ^ symbol_now;
                    if (chip_index == `LAST_CHIP_INDEX) begin
                        next_chip_index = 10'h000;
                        next_first_feedback_register = `REGISTER_ALL_ONES;
                        next_second_feedback_register = second_base;
                    end else begin
                        next_chip_index = chip_index + 10'h001;
                        next_first_feedback_register = step_first(first_feedback_register);
                        next_second_feedback_register = step_second(second_feedback_register);
                    end
                end
                if (halt) begin
                    next_state = aug_prn_pkg::state_idle;
                    next_running = 1'b0;
                end
            end
            default: begin
                next_state = aug_prn_pkg::state_idle;
                next_running = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= aug_prn_pkg::state_idle;
            first_feedback_register <= `REGISTER_ALL_ONES;
            second_feedback_register <= `REGISTER_ALL_ONES;
            second_base <= `REGISTER_ALL_ONES;
            chip_index <= 10'h000;
            seek_count <= 10'h000;
            phase <= 32'h00000000;
            symbol_half <= 1'b0;
            symbol <= 1'b0;
            code_chip <= 1'b0;
            tx_chip <= 1'b0;
            chip_strobe <= 1'b0;
            epoch <= 1'b0;
            symbol_take <= 1'b0;
            running <= 1'b0;
            select_error <= 1'b0;
        end else begin
            state <= next_state;
            first_feedback_register <= next_first_feedback_register;
            second_feedback_register <= next_second_feedback_register;
            second_base <= next_second_base;
            chip_index <= next_chip_index;
            seek_count <= next_seek_count;
            phase <= next_phase;
            symbol_half <= next_symbol_half;
            symbol <= next_symbol;
            code_chip <= next_code_chip;
            tx_chip <= next_tx_chip;
            chip_strobe <= next_chip_strobe;
            epoch <= next_epoch;
            symbol_take <= next_symbol_take;
            running <= next_running;
            select_error <= next_select_error;
        end
    end

endmodule

// *** verification/augmentation_prn_code_generator_assertions.sv ***
`timescale 1ns/1ps
module augmentation_prn_code_generator_checker #(
    parameter logic [31:0] CODE_STEP = 32'h80000000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Selection
    input wire logic start,
    input wire logic halt,
    input wire logic [1:0] code_select,
    input wire logic [7:0] prn_number,
    input wire logic [9:0] second_register_chip_delay,
    // Chip stream
    input wire logic code_chip,
    input wire logic tx_chip,
    input wire logic chip_strobe,
    input wire logic epoch,
    input wire logic symbol_take,
    input wire logic running,
    input wire logic select_error
);
    logic busy, next_busy, seen, next_seen, bad_sel, good_sel;
    logic [9:0] count, next_count;
    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        bad_sel = code_select == 2'h3
            || (code_select == 2'h1 && second_register_chip_delay == 10'h3FF)
            || (code_select == 2'h0 && (prn_number < 8'h78 || prn_number > 8'h8A));
        good_sel = start && !busy && !bad_sel;
        // Halt is ignored while idle, so it cannot cancel a start
        next_busy = good_sel || (busy && !halt);
        next_seen = !(good_sel || halt) && (seen || (chip_strobe && epoch));
        next_count = !chip_strobe ? count : (epoch ? 10'h000 : count + 10'h001);
    end
    always_ff @(posedge clock) begin
        busy <= reset ? 1'b0 : next_busy;
        seen <= reset ? 1'b0 : next_seen;
        count <= reset ? 10'h000 : next_count;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_epoch_strobe; epoch |-> chip_strobe; endproperty
    a_epoch_strobe: assert property (p_epoch_strobe) else $error("epoch off strobe");
    property p_take_epoch; symbol_take |-> epoch; endproperty
    a_take_epoch: assert property (p_take_epoch) else $error("take off epoch");
    property p_strobe_pulse; chip_strobe |=> !chip_strobe; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
    property p_start_ok;
        good_sel && (code_select != 2'h1 || second_register_chip_delay == 10'h000)
            |=> running && !select_error;
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("valid start not run");
    property p_start_bad; start && !busy && bad_sel |=> select_error && !running; endproperty
    a_start_bad: assert property (p_start_bad) else $error("bad start accepted");
    property p_seek; good_sel && code_select == 2'h1 && second_register_chip_delay != 10'h000
        |=> !running; endproperty
    a_seek: assert property (p_seek) else $error("delay without seek");
    property p_halt; halt && busy |=> !running; endproperty
    a_halt: assert property (p_halt) else $error("halt ignored");
    property p_period; chip_strobe && seen |-> epoch == (count == 10'h3FE); endproperty
    a_period: assert property (p_period) else $error("period not 1023");
    property p_held; running && $past(running) && !chip_strobe
        |-> $stable(code_chip) && $stable(tx_chip); endproperty
    a_held: assert property (p_held) else $error("chip moved off strobe");
endmodule

bind augmentation_prn_code_generator augmentation_prn_code_generator_checker #(
    .CODE_STEP(CODE_STEP)
) checker_i (.clock(clock), .reset(reset), .start(start), .halt(halt),
    .code_select(code_select), .prn_number(prn_number),
    .second_register_chip_delay(second_register_chip_delay), .code_chip(code_chip),
    .tx_chip(tx_chip), .chip_strobe(chip_strobe), .epoch(epoch),
    .symbol_take(symbol_take), .running(running), .select_error(select_error));

// *** verification/augmentation_prn_code_generator_bench.sv ***
`timescale 1ns/1ps
module augmentation_prn_code_generator_bench;
    logic clock, reset, start, halt, data_symbol, code_chip, tx_chip, chip_strobe;
    logic epoch, symbol_take, running, select_error, seeking;
    logic [1:0] code_select;
    logic [7:0] prn_number;
    logic [9:0] second_register_chip_delay, second_register_start_state, st;
    logic [10:0] period_length;
    int fails, checked, seed;
    logic [9:0] states [19] = '{10'h246, 10'h2A1, 10'h0B7, 10'h09A, 10'h38F, 10'h23E, 10'h3F4,
        10'h1CF, 10'h35A, 10'h2A8, 10'h0E1, 10'h169, 10'h150, 10'h3D9, 10'h1C6, 10'h28E, 10'h1E0,
        10'h207, 10'h128};
    logic [9:0] delays [19] = '{10'h091, 10'h0AF, 10'h034, 10'h015, 10'h0ED, 10'h0EB, 10'h376,
        10'h291, 10'h27A, 10'h2FA, 10'h163, 10'h3F4, 10'h0B0, 10'h25B, 10'h082, 10'h167, 10'h253,
        10'h044, 10'h182};
    augmentation_prn_code_generator #(.CODE_STEP(32'h80000000)) augmentation_prn_code_generator_i (
        .clock(clock), .reset(reset), .start(start), .halt(halt), .code_select(code_select),
        .prn_number(prn_number), .second_register_chip_delay(second_register_chip_delay),
        .second_register_start_state(second_register_start_state), .data_symbol(data_symbol),
        .code_chip(code_chip), .tx_chip(tx_chip), .chip_strobe(chip_strobe), .epoch(epoch),
        .symbol_take(symbol_take), .running(running), .select_error(select_error));
    chip_correlator chip_correlator_i (.clock(clock), .reset(reset), .chip_strobe(chip_strobe),
        .epoch(epoch), .period_length(period_length));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic pulse(input logic [1:0] sel, input logic [7:0] prn, input logic [9:0] dly,
                         input logic [9:0] state);
        @(posedge clock);
        start <= 1'b1;
        code_select <= sel;
        prn_number <= prn;
        second_register_chip_delay <= dly;
        second_register_start_state <= state;
        @(posedge clock);
        start <= 1'b0;
    endtask
    task automatic stop;
        @(posedge clock);
        halt <= 1'b1;
        @(posedge clock);
        halt <= 1'b0;
        @(negedge clock);
        check("halt", running, 1'b0);
    endtask
    // Model first register starts all ones, second from the base state passed in, independent of the design
    task automatic run(input logic [1:0] sel, input logic [7:0] prn, input logic [9:0] dly,
                       input logic [9:0] state, input logic [9:0] base, input int n);
        logic [9:0] g1, g2;
        int k, t;
        logic sym;
        pulse(sel, prn, dly, state);
        t = 0;
        do begin
            @(negedge clock);
            t++;
        end while (running !== 1'b1 && t < 1100);
        check("latency", 11'(t), (sel == 2'h1 && |dly) ? 11'h400 - dly : 11'h001);
        check("error", select_error, 1'b0);
        g1 = 10'h3FF;
        g2 = base;
        k = 0;
        sym = 1'b0;
        while (k < n) begin
            @(negedge clock);
            if (chip_strobe === 1'b1) begin
                if (k % 2046 == 0) sym = data_symbol;
                check("code", code_chip, g1[9] ^ g2[9]);
                check("tx", tx_chip, g1[9] ^ g2[9] ^ sym);
                check("epoch", epoch, k % 1023 == 0);
                check("take", symbol_take, k % 2046 == 0);
                g1 = {g1[8:0], ^(g1 & 10'h204)};
                g2 = {g2[8:0], ^(g2 & 10'h3A6)};
                k++;
            end
        end
        stop;
    endtask
    task automatic conclude;
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Sole driver of the symbol input
    always @(posedge clock) begin
        if (reset) begin
            data_symbol <= 1'b0;
        end else if (symbol_take === 1'b1) begin
            data_symbol <= 1'($random(seed));
        end
    end
    initial begin
        #400000;
        fails++;
        conclude;
    end
    initial begin
        seed = 32'hE8A5CA35;
        {fails, checked, start, halt, code_select, prn_number} = '0;
        {second_register_chip_delay, second_register_start_state} = '0;
        reset = 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        run(2'h0, 8'h78, 10'h000, 10'h000, 10'h246, 2100);
        check("period", period_length, 11'h3FF);
        for (int i = 0; i < 19; i++) begin
            run(2'h0, 8'(8'h78 + i), 10'h000, 10'h000, states[i], 24);
            run(2'h1, 8'h00, delays[i], 10'h000, states[i], 24);
        end
        run(2'h1, 8'h00, 10'h000, 10'h000, 10'h3FF, 24);
        for (int i = 0; i < 4; i++) begin
            st = 10'($random(seed)) | 10'h001;
            run(2'h2, 8'h00, 10'h000, st, st, 24);
        end
        pulse(2'h3, 8'h78, 10'h000, 10'h000);
        @(negedge clock);
        check("sel3", {select_error, running}, 2'b10);
        pulse(2'h0, 8'h77, 10'h000, 10'h000);
        @(negedge clock);
        check("prn119", {select_error, running}, 2'b10);
        pulse(2'h0, 8'h8B, 10'h000, 10'h000);
        @(negedge clock);
        check("prn139", {select_error, running}, 2'b10);
        pulse(2'h1, 8'h00, 10'h3FF, 10'h000);
        @(negedge clock);
        check("dly1023", {select_error, running}, 2'b10);
        pulse(2'h1, 8'h00, 10'h00A, 10'h000);
        repeat (5) @(posedge clock);
        stop;
        seeking = 1'b0;
        repeat (1100) begin
            @(negedge clock);
            seeking = seeking | running;
        end
        check("abort", seeking, 1'b0);
        run(2'h0, 8'h8A, 10'h000, 10'h000, states[18], 24);
        conclude;
    end
endmodule

// *** verification/chip_correlator.sv ***
`timescale 1ns/1ps
module chip_correlator (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Chip stream
    input wire logic chip_strobe,
    input wire logic epoch,
    // Measured period
    output logic [10:0] period_length
);
    logic [10:0] count;
    // Locks to any code period, allocated or not
    always @(posedge clock) begin
        if (reset) begin
            count <= 11'h000;
            period_length <= 11'h000;
        end else if (chip_strobe && epoch) begin
            period_length <= count;
            count <= 11'h001;
        end else if (chip_strobe) begin
            count <= count + 11'h001;
        end
    end
endmodule
